/* File: common/meq_consts.vh */
// Constants for the channel event queue and transmit closing block
`ifndef MEQ_CONSTS_VH
`define MEQ_CONSTS_VH

// Register indices; byte address is four times the index
`define MEQ_IDX_RSVD_A     8'h38
`define MEQ_IDX_SLOT_ALIGN 8'h3c
`define MEQ_IDX_RSVD_B     8'h3e
`define MEQ_IDX_CHAN_MODE  8'h40
`define MEQ_IDX_EVT_ENABLE 8'h41
`define MEQ_IDX_CHAN_EVT   8'h42
`define MEQ_IDX_CHAN_MASK  8'h43
`define MEQ_IDX_QUEUE_STAT 8'h44
`define MEQ_IDX_TXD_STAT   8'h45
`define MEQ_IDX_TXD_LEN    8'h46
`define MEQ_IDX_TXD_PTR    8'h47

// Reset values
`define MEQ_RST_WORD16     16'h0000
`define MEQ_RST_WORD32     32'h00000000

// Channel mode word fields
`define MEQ_MODE_IDLE_SEL  13
`define MEQ_MODE_SYNC_EN   10

// Queue entry and enable mask fields
`define MEQ_ENT_VALID      15
`define MEQ_ENT_WRAP       14
`define MEQ_ENT_CHAN_LSB   6
`define MEQ_ENT_STARVED    4
`define MEQ_ENT_NO_BUF     2
`define MEQ_ENT_TX_DONE    1
`define MEQ_ENT_RX_DONE    0
`define MEQ_EVT_FIELDS     16'h0017

// Channel event register fields
`define MEQ_CE_RX_OVF      0
`define MEQ_CE_TX_STARVE   1
`define MEQ_CE_QUEUE_NEW   2

// Transmit descriptor status fields
`define MEQ_TXD_READY      15
`define MEQ_TXD_REPEAT     9
`define MEQ_TXD_SW_FLAG    7
`define MEQ_TXD_PAD_LSB    0

// Pad characters
`define MEQ_PAD_FLAG       8'h7e
`define MEQ_PAD_ONES       8'hff

// Bus responses
`define MEQ_RESP_OKAY      2'b00
`define MEQ_RESP_SLVERR    2'b10

`endif

/* File: core/meq_top.v */
// Channel event queue, global errors and transmit buffer closing
`timescale 1ns/1ps
`default_nettype none
`include "meq_consts.vh"

module meq_top #(
	parameter QUEUE_DEPTH = 16,
	parameter QIDX_W      = 4
) (
	// Clock and reset
	input  wire              CLOCK_I,
	input  wire              SYS_RST_I,
	// AXI4-Lite write address and data
	input  wire [9:0]        S_AXI_AWADDR_I,
	input  wire              S_AXI_AWVALID_I,
	output reg               S_AXI_AWREADY_O,
	input  wire [31:0]       S_AXI_WDATA_I,
	input  wire [3:0]        S_AXI_WSTRB_I,
	input  wire              S_AXI_WVALID_I,
	output reg               S_AXI_WREADY_O,
	// AXI4-Lite write response
	output reg  [1:0]        S_AXI_BRESP_O,
	output reg               S_AXI_BVALID_O,
	input  wire              S_AXI_BREADY_I,
	// AXI4-Lite read
	input  wire [9:0]        S_AXI_ARADDR_I,
	input  wire              S_AXI_ARVALID_I,
	output reg               S_AXI_ARREADY_O,
	output reg  [31:0]       S_AXI_RDATA_O,
	output reg  [1:0]        S_AXI_RRESP_O,
	output reg               S_AXI_RVALID_O,
	input  wire              S_AXI_RREADY_I,
	// Host interrupt
	output reg               HOST_IRQ_O,
	// Channel events from the protocol engine
	input  wire              CH_EVT_VALID_I,
	output reg               CH_EVT_READY_O,
	input  wire [4:0]        CH_EVT_CHAN_I,
	input  wire [15:0]       CH_EVT_FLAGS_I,
	// Queue entry write port to memory
	output reg               QW_VALID_O,
	input  wire              QW_READY_I,
	output reg  [QIDX_W-1:0] QW_INDEX_O,
	output reg  [15:0]       QW_DATA_O,
	// Global error sources
	input  wire              RX_XFER_REQ_I,
	input  wire              RX_XFER_SRV_I,
	input  wire              TX_XFER_REQ_I,
	input  wire              TX_XFER_SRV_I,
	input  wire              RX_FIFO_OVERWRITE_I,
	input  wire              TX_FIFO_STARVE_I,
	// Transmit closing
	input  wire [4:0]        TX_CHAN_I,
	input  wire              TX_CLOSE_FLAG_I,
	output wire              TX_PAD_VALID_O,
	output wire [7:0]        TX_PAD_CHAR_O,
	input  wire              TX_PAD_TAKEN_I,
	// Descriptor fields to the memory mover
	output wire              TX_BUF_READY_O,
	output wire [15:0]       TX_BUF_LEN_O,
	output wire [31:0]       TX_BUF_PTR_O,
	// Slot alignment
	output reg  [7:0]        RX_FIRST_SLOT_O,
	output reg  [7:0]        TX_ALIGN_O
);

	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = data[i*8 +: 8];
				end
			end
		end
	endfunction

	function mapped;
		input [7:0] idx;
		begin
			mapped = (idx == `MEQ_IDX_RSVD_A) || (idx == `MEQ_IDX_SLOT_ALIGN) ||
				(idx == `MEQ_IDX_RSVD_B) ||
				((idx >= `MEQ_IDX_CHAN_MODE) && (idx <= `MEQ_IDX_TXD_PTR));
		end
	endfunction

	// Software registers
	reg  [15:0]       slot_align;
	reg  [15:0]       chan_mode;
	reg  [15:0]       evt_enable;
	reg  [2:0]        chan_evt;
	reg  [2:0]        chan_mask;
	reg  [15:0]       txd_stat;
	reg  [15:0]       txd_len;
	reg  [31:0]       txd_ptr;
	reg  [2:0]        next_chan_evt;
	reg  [15:0]       next_txd_stat;

	// Bus state
	reg               aw_held;
	reg               w_held;
	reg  [7:0]        aw_idx;
	reg  [31:0]       w_data;
	reg  [3:0]        w_strb;
	reg               next_aw_held;
	reg               next_w_held;
	reg               next_bvalid;
	reg               next_rvalid;
	reg  [31:0]       rd_mux;

	// Queue and error state
	reg               rx_pend;
	reg               tx_pend;
	reg               txb_pend;
	reg  [QIDX_W-1:0] q_idx;
	reg               next_qw_valid;
	reg               q_written;
	reg               load_txb;
	reg  [15:0]       load_flags;
	reg  [4:0]        load_chan;
	reg               load;
	wire              tx_done;
	wire              aw_take  = S_AXI_AWREADY_O & S_AXI_AWVALID_I;
	wire              w_take   = S_AXI_WREADY_O & S_AXI_WVALID_I;
	wire              ar_take  = S_AXI_ARREADY_O & S_AXI_ARVALID_I;
	wire              do_write = aw_held & w_held & ~S_AXI_BVALID_O;
	wire [31:0]       wr_val   = merge(32'h00000000, w_data, w_strb);
	wire              ext_take = CH_EVT_READY_O & CH_EVT_VALID_I;
	wire [15:0]       ext_flags = CH_EVT_FLAGS_I & evt_enable & `MEQ_EVT_FIELDS;
	wire              rx_ovf   = (RX_XFER_REQ_I & rx_pend & ~RX_XFER_SRV_I) |
		RX_FIFO_OVERWRITE_I;
	wire              tx_starve = (TX_XFER_REQ_I & tx_pend & ~TX_XFER_SRV_I) |
		TX_FIFO_STARVE_I;
	wire              sync_en  = chan_mode[`MEQ_MODE_SYNC_EN];

	////////////////////////////////////////////////////////////////////////
	// Pad insertion after the closing flag
	meq_tx_close u_close (
		.clk_i       (CLOCK_I),
		.rst_i       (SYS_RST_I),
		.close_i     (TX_CLOSE_FLAG_I),
		.pad_count_i (txd_stat[`MEQ_TXD_PAD_LSB +: 4]),
		.idle_sel_i  (chan_mode[`MEQ_MODE_IDLE_SEL]),
		.pad_valid_o (TX_PAD_VALID_O),
		.pad_char_o  (TX_PAD_CHAR_O),
		.pad_taken_i (TX_PAD_TAKEN_I),
		.done_o      (tx_done)
	);

	assign TX_BUF_READY_O = txd_stat[`MEQ_TXD_READY];
	assign TX_BUF_LEN_O   = txd_len;
	assign TX_BUF_PTR_O   = txd_ptr;

	////////////////////////////////////////////////////////////////////////
	// Bus handshake next state
	always @* begin
		next_aw_held = (aw_held & ~do_write) | aw_take;
		next_w_held  = (w_held & ~do_write) | w_take;
		next_bvalid  = (S_AXI_BVALID_O & ~S_AXI_BREADY_I) | do_write;
		next_rvalid  = (S_AXI_RVALID_O & ~S_AXI_RREADY_I) | ar_take;
	end

	// Read mux, reserved words read zero
	always @* begin
		case (S_AXI_ARADDR_I[9:2])
		`MEQ_IDX_SLOT_ALIGN: rd_mux = {16'h0000, slot_align};
		`MEQ_IDX_CHAN_MODE:  rd_mux = {16'h0000, chan_mode};
		`MEQ_IDX_EVT_ENABLE: rd_mux = {16'h0000, evt_enable};
		`MEQ_IDX_CHAN_EVT:   rd_mux = {{29{1'b0}}, chan_evt};
		`MEQ_IDX_CHAN_MASK:  rd_mux = {{29{1'b0}}, chan_mask};
		`MEQ_IDX_QUEUE_STAT: rd_mux = {{(32-QIDX_W){1'b0}}, q_idx};
		`MEQ_IDX_TXD_STAT:   rd_mux = {16'h0000, txd_stat};
		`MEQ_IDX_TXD_LEN:    rd_mux = {16'h0000, txd_len};
		`MEQ_IDX_TXD_PTR:    rd_mux = txd_ptr;
		default:             rd_mux = 32'h00000000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Queue writer next state
	always @* begin
		q_written     = QW_VALID_O & QW_READY_I;
		next_qw_valid = QW_VALID_O & ~QW_READY_I;
		load          = 1'b0;
		load_txb      = 1'b0;
		load_flags    = 16'h0000;
		load_chan     = CH_EVT_CHAN_I;
		if (!QW_VALID_O) begin
			if (ext_take && (ext_flags != 16'h0000)) begin
				load       = 1'b1;
				load_flags = ext_flags;
			end else if (!ext_take && txb_pend) begin
				load_txb = 1'b1;
				if (evt_enable[`MEQ_ENT_TX_DONE]) begin
					load       = 1'b1;
					load_chan  = TX_CHAN_I;
					load_flags = 16'h0000;
					load_flags[`MEQ_ENT_TX_DONE] = 1'b1;
				end
			end
		end
		next_qw_valid = next_qw_valid | load;
	end

	// Event register: hardware set wins over software clear
	always @* begin
		next_chan_evt = chan_evt;
		if (do_write && (aw_idx == `MEQ_IDX_CHAN_EVT)) begin
			next_chan_evt = chan_evt & ~wr_val[2:0];
		end
		if (rx_ovf) begin
			next_chan_evt[`MEQ_CE_RX_OVF] = 1'b1;
		end
		if (tx_starve) begin
			next_chan_evt[`MEQ_CE_TX_STARVE] = 1'b1;
		end
		if (q_written) begin
			next_chan_evt[`MEQ_CE_QUEUE_NEW] = 1'b1;
		end
	end

	// Descriptor status: ready cleared on close unless repeating
	always @* begin
		next_txd_stat = txd_stat;
		if (tx_done && !txd_stat[`MEQ_TXD_REPEAT]) begin
			next_txd_stat[`MEQ_TXD_READY] = 1'b0;
		end
		if (do_write && (aw_idx == `MEQ_IDX_TXD_STAT)) begin
			next_txd_stat = wr_merge16(txd_stat);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	always @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			aw_held         <= 1'b0;
			w_held          <= 1'b0;
			aw_idx          <= 8'h00;
			w_data          <= 32'h00000000;
			w_strb          <= 4'h0;
			S_AXI_AWREADY_O <= 1'b0;
			S_AXI_WREADY_O  <= 1'b0;
			S_AXI_BVALID_O  <= 1'b0;
			S_AXI_BRESP_O   <= `MEQ_RESP_OKAY;
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O  <= 1'b0;
			S_AXI_RDATA_O   <= 32'h00000000;
			S_AXI_RRESP_O   <= `MEQ_RESP_OKAY;
		end else begin
			aw_held         <= next_aw_held;
			w_held          <= next_w_held;
			S_AXI_AWREADY_O <= ~next_aw_held & ~next_bvalid;
			S_AXI_WREADY_O  <= ~next_w_held & ~next_bvalid;
			S_AXI_BVALID_O  <= next_bvalid;
			S_AXI_ARREADY_O <= ~next_rvalid;
			S_AXI_RVALID_O  <= next_rvalid;
			if (aw_take) begin
				aw_idx <= S_AXI_AWADDR_I[9:2];
			end
			if (w_take) begin
				w_data <= S_AXI_WDATA_I;
				w_strb <= S_AXI_WSTRB_I;
			end
			if (do_write) begin
				S_AXI_BRESP_O <= mapped(aw_idx) ? `MEQ_RESP_OKAY : `MEQ_RESP_SLVERR;
			end
			if (ar_take) begin
				S_AXI_RDATA_O <= rd_mux;
				S_AXI_RRESP_O <= mapped(S_AXI_ARADDR_I[9:2]) ?
					`MEQ_RESP_OKAY : `MEQ_RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers; length and pointer change only by software
	always @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			slot_align <= `MEQ_RST_WORD16;
			chan_mode  <= `MEQ_RST_WORD16;
			evt_enable <= `MEQ_RST_WORD16;
			chan_evt   <= 3'h0;
			chan_mask  <= 3'h0;
			txd_stat   <= `MEQ_RST_WORD16;
			txd_len    <= `MEQ_RST_WORD16;
			txd_ptr    <= `MEQ_RST_WORD32;
		end else begin
			chan_evt <= next_chan_evt;
			txd_stat <= next_txd_stat;
			if (do_write) begin
				case (aw_idx)
				`MEQ_IDX_SLOT_ALIGN: slot_align <= wr_merge16(slot_align);
				`MEQ_IDX_CHAN_MODE:  chan_mode  <= wr_merge16(chan_mode);
				`MEQ_IDX_EVT_ENABLE: evt_enable <= wr_merge16(evt_enable);
				`MEQ_IDX_CHAN_MASK:  chan_mask  <= wr_val[2:0];
				`MEQ_IDX_TXD_LEN:    txd_len    <= wr_merge16(txd_len);
				`MEQ_IDX_TXD_PTR:    txd_ptr    <= merge(txd_ptr, w_data, w_strb);
				default:             chan_mask  <= chan_mask;
				endcase
			end
		end
	end

	function [15:0] wr_merge16;
		input [15:0] old;
		reg   [31:0] m;
		begin
			m          = merge({16'h0000, old}, w_data, w_strb);
			wr_merge16 = m[15:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Global error request tracking, queue writer and interrupt
	always @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			rx_pend        <= 1'b0;
			tx_pend        <= 1'b0;
			txb_pend       <= 1'b0;
			q_idx          <= {QIDX_W{1'b0}};
			QW_VALID_O     <= 1'b0;
			QW_INDEX_O     <= {QIDX_W{1'b0}};
			QW_DATA_O      <= 16'h0000;
			CH_EVT_READY_O <= 1'b0;
			HOST_IRQ_O     <= 1'b0;
			RX_FIRST_SLOT_O <= 8'h00;
			TX_ALIGN_O     <= 8'h00;
		end else begin
			rx_pend <= (rx_pend & ~RX_XFER_SRV_I) | RX_XFER_REQ_I;
			tx_pend <= (tx_pend & ~TX_XFER_SRV_I) | TX_XFER_REQ_I;
			txb_pend <= (txb_pend & ~load_txb) | tx_done;
			QW_VALID_O     <= next_qw_valid;
			CH_EVT_READY_O <= ~next_qw_valid;
			if (load) begin
				QW_INDEX_O <= q_idx;
				QW_DATA_O  <= load_flags;
				QW_DATA_O[`MEQ_ENT_VALID] <= 1'b1;
				QW_DATA_O[`MEQ_ENT_WRAP]  <= (q_idx == QUEUE_DEPTH - 1);
				QW_DATA_O[`MEQ_ENT_CHAN_LSB +: 5] <= load_chan;
			end
			if (q_written) begin
				q_idx <= (q_idx == QUEUE_DEPTH - 1) ? {QIDX_W{1'b0}} :
					q_idx + {{(QIDX_W-1){1'b0}}, 1'b1};
			end
			HOST_IRQ_O <= |(next_chan_evt & chan_mask);
			RX_FIRST_SLOT_O <= sync_en ? slot_align[15:8] : 8'h00;
			TX_ALIGN_O      <= sync_en ? slot_align[7:0] : 8'h00;
		end
	end

endmodule // meq_top

`default_nettype wire

/* File: core/meq_tx_close.v */
// Trailing pad insertion and transmit done timing
`timescale 1ns/1ps
`default_nettype none
`include "meq_consts.vh"

module meq_tx_close (
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// Closing flag and pad setup
	input  wire       close_i,
	input  wire [3:0] pad_count_i,
	input  wire       idle_sel_i,
	// Pad character stream
	output reg        pad_valid_o,
	output reg  [7:0] pad_char_o,
	input  wire       pad_taken_i,
	// Completion
	output reg        done_o
);

	localparam ST_IDLE = 1'b0;
	localparam ST_PAD  = 1'b1;

	reg       state;
	reg [3:0] remain;

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		if (rst_i) begin
			state       <= ST_IDLE;
			remain      <= 4'h0;
			pad_valid_o <= 1'b0;
			pad_char_o  <= `MEQ_PAD_FLAG;
			done_o      <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (close_i) begin
					if (pad_count_i == 4'h0) begin
						done_o <= 1'b1;
					end else begin
						state       <= ST_PAD;
						remain      <= pad_count_i;
						pad_valid_o <= 1'b1;
						pad_char_o  <= idle_sel_i ? `MEQ_PAD_ONES : `MEQ_PAD_FLAG;
					end
				end
			end
			ST_PAD: begin
				if (pad_taken_i) begin
					if (remain == 4'h1) begin
						state       <= ST_IDLE;
						pad_valid_o <= 1'b0;
						done_o      <= 1'b1;
					end
					remain <= remain - 4'h1;
				end
			end
			default: begin
				state       <= ST_IDLE;
				pad_valid_o <= 1'b0;
			end
			endcase
		end
	end

endmodule // meq_tx_close

`default_nettype wire

/* File: tb/meq_asserts.sv */
// Concurrent checks on the event queue and transmit closing ports
`timescale 1ns/1ps
`default_nettype none
module meq_asserts #(
	parameter int QUEUE_DEPTH = 16,
	parameter int QIDX_W      = 4
) (
	// Clock, reset, bus and interrupt
	input wire logic              CLOCK_I,
	input wire logic              SYS_RST_I,
	input wire logic              S_AXI_BVALID_O,
	input wire logic              HOST_IRQ_O,
	// Queue entry port
	input wire logic              QW_VALID_O,
	input wire logic              QW_READY_I,
	input wire logic [QIDX_W-1:0] QW_INDEX_O,
	input wire logic [15:0]       QW_DATA_O,
	// Transmit closing and descriptor
	input wire logic              TX_PAD_VALID_O,
	input wire logic [7:0]        TX_PAD_CHAR_O,
	input wire logic              TX_PAD_TAKEN_I,
	input wire logic              TX_BUF_READY_O,
	input wire logic [15:0]       TX_BUF_LEN_O,
	input wire logic [31:0]       TX_BUF_PTR_O,
	input wire logic [7:0]        RX_FIRST_SLOT_O,
	input wire logic [7:0]        TX_ALIGN_O
);
default clocking @(posedge CLOCK_I); endclocking
default disable iff (SYS_RST_I);
////////////////////////////////////////////////////////////////////////////////
logic [QIDX_W-1:0] last_idx;
logic [QIDX_W-1:0] next_idx;
logic              have_last;
assign next_idx = (last_idx == QIDX_W'(QUEUE_DEPTH - 1)) ? '0 : last_idx + 1'h1;
always @(posedge CLOCK_I) begin
	if (SYS_RST_I) begin
		have_last <= 1'h0;
		last_idx  <= '0;
	end else if (QW_VALID_O && QW_READY_I) begin
		have_last <= 1'h1;
		last_idx  <= QW_INDEX_O;
	end
end
////////////////////////////////////////////////////////////////////////////////
chk_entry_fields: assert property (QW_VALID_O |-> QW_DATA_O[15] && (QW_DATA_O & 16'h3828) == 16'h0)
	else $error("queue entry lacks valid flag or has reserved bits set");
chk_wrap_flag: assert property (QW_VALID_O |-> QW_DATA_O[14] == (QW_INDEX_O == QUEUE_DEPTH - 1))
	else $error("wrap flag does not match last queue slot");
chk_index_next: assert property ($rose(QW_VALID_O) && have_last |-> QW_INDEX_O == next_idx)
	else $error("queue slot did not advance or wrap");
chk_entry_hold: assert property (QW_VALID_O && !QW_READY_I |=> QW_VALID_O && $stable(QW_DATA_O))
	else $error("queue entry changed before it was taken");
chk_pad_hold: assert property (TX_PAD_VALID_O && !TX_PAD_TAKEN_I |=> TX_PAD_VALID_O)
	else $error("pad character withdrawn before it was taken");
chk_pad_char: assert property (TX_PAD_VALID_O |-> TX_PAD_CHAR_O inside {8'h7e, 8'hff})
	else $error("pad character is neither flag nor ones");
chk_close_pads: assert property ($fell(TX_BUF_READY_O) |-> !TX_PAD_VALID_O)
	else $error("buffer closed while pads still pending");
chk_desc_fixed: assert property ($changed(TX_BUF_LEN_O) || $changed(TX_BUF_PTR_O)
	|-> S_AXI_BVALID_O || $past(S_AXI_BVALID_O)) else $error("descriptor length or pointer altered");
chk_align_write: assert property ($changed(RX_FIRST_SLOT_O) || $changed(TX_ALIGN_O)
	|-> S_AXI_BVALID_O || $past(S_AXI_BVALID_O)) else $error("alignment outputs moved without write");
cov_wrap: cover property (QW_VALID_O && QW_READY_I && QW_DATA_O[14]);
cov_pad: cover property (TX_PAD_VALID_O && TX_PAD_TAKEN_I);
cov_irq: cover property ($rose(HOST_IRQ_O));
cov_close: cover property ($fell(TX_BUF_READY_O));
endmodule // meq_asserts
bind meq_top meq_asserts #(.QUEUE_DEPTH(QUEUE_DEPTH), .QIDX_W(QIDX_W)) u_chk (
	.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .S_AXI_BVALID_O(S_AXI_BVALID_O),
	.HOST_IRQ_O(HOST_IRQ_O), .QW_VALID_O(QW_VALID_O), .QW_READY_I(QW_READY_I),
	.QW_INDEX_O(QW_INDEX_O), .QW_DATA_O(QW_DATA_O), .TX_PAD_VALID_O(TX_PAD_VALID_O),
	.TX_PAD_CHAR_O(TX_PAD_CHAR_O), .TX_PAD_TAKEN_I(TX_PAD_TAKEN_I),
	.TX_BUF_READY_O(TX_BUF_READY_O), .TX_BUF_LEN_O(TX_BUF_LEN_O), .TX_BUF_PTR_O(TX_BUF_PTR_O),
	.RX_FIRST_SLOT_O(RX_FIRST_SLOT_O), .TX_ALIGN_O(TX_ALIGN_O)
);
`default_nettype wire

/* File: tb/meq_queue_mem.sv */
// Host memory holding the circular event queue
`timescale 1ns/1ps
`default_nettype none
module meq_queue_mem #(
	parameter int QUEUE_DEPTH = 16,
	parameter int QIDX_W      = 4
) (
	// Clock, reset and pacing
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              stall_i,
	// Entry write port
	input  wire logic              qw_valid_i,
	input  wire logic [QIDX_W-1:0] qw_index_i,
	input  wire logic [15:0]       qw_data_i,
	output logic                   qw_ready_o,
	output logic [15:0]            wr_count_o
);
logic [15:0] mem [QUEUE_DEPTH];
logic [7:0]  lfsr;
// Slow mode answers on a pseudo random pattern
always @(posedge clk_i) begin
	if (rst_i) begin
		lfsr       <= 8'h5a;
		qw_ready_o <= 1'h0;
		wr_count_o <= 16'h0;
	end else begin
		lfsr       <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		qw_ready_o <= !stall_i || lfsr[0];
		if (qw_valid_i && qw_ready_o) begin
			mem[qw_index_i] <= qw_data_i;
			wr_count_o      <= wr_count_o + 16'h1;
		end
	end
end
// Serviced entry loses valid and every flag
task automatic clear_entry(input logic [QIDX_W-1:0] idx);
	mem[idx] = 16'h0;
endtask
endmodule // meq_queue_mem
`default_nettype wire

/* File: tb/meq_top_test.sv */
// Self-checking bench for the event queue and transmit closing block
`timescale 1ns/1ps
`default_nettype none
`include "meq_consts.vh"
`define MEQ_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end
module meq_top_test;
localparam int DEPTH = 16;
localparam int IW    = 4;
logic        clk = 1'h0, rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
logic        arvalid = 1'h0, rready = 1'h0, ev_valid = 1'h0, close = 1'h0, taken = 1'h0;
logic        stall = 1'h0;
logic [9:0]  awaddr = 10'h0, araddr = 10'h0;
logic [31:0] wdata = 32'h0, d, len, ptr;
logic [4:0]  ev_chan = 5'h0, tx_chan = 5'h0;
logic [15:0] ev_flags = 16'h0, en, fl;
logic [5:0]  gerr = 6'h0;
logic [1:0]  r;
wire         awready, wready, bvalid, arready, rvalid, irq, ev_ready, qw_valid, qw_ready;
wire         pad_valid, buf_ready;
wire [1:0]   bresp, rresp;
wire [31:0]  rdata, buf_ptr;
wire [IW-1:0] qw_index;
wire [15:0]  qw_data, buf_len, wr_count;
wire [7:0]   pad_char, first_slot, tx_align;
int          seed = 37, miscompares = 0, cmp_count = 0, exp_idx = 0, n;
logic [5:0]  gp1 [5] = '{6'h10, 6'h20, 6'h01, 6'h04, 6'h01};
logic [5:0]  gp2 [5] = '{6'h00, 6'h00, 6'h01, 6'h04, 6'h03};
logic [5:0]  gp3 [5] = '{6'h00, 6'h00, 6'h02, 6'h08, 6'h02};
logic [2:0]  gexp [5] = '{3'h1, 3'h2, 3'h1, 3'h2, 3'h0};
logic [3:0]  tpad [4] = '{4'h0, 4'h1, 4'h3, 4'hf};
logic [1:0]  tmode [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
always #2 clk = ~clk;
////////////////////////////////////////////////////////////////////////////////
meq_top #(.QUEUE_DEPTH(DEPTH), .QIDX_W(IW)) u_dut (
	.CLOCK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
	.S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf),
	.S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
	.S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
	.S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
	.S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .HOST_IRQ_O(irq),
	.CH_EVT_VALID_I(ev_valid), .CH_EVT_READY_O(ev_ready), .CH_EVT_CHAN_I(ev_chan),
	.CH_EVT_FLAGS_I(ev_flags), .QW_VALID_O(qw_valid), .QW_READY_I(qw_ready),
	.QW_INDEX_O(qw_index), .QW_DATA_O(qw_data), .RX_XFER_REQ_I(gerr[0]), .RX_XFER_SRV_I(gerr[1]),
	.TX_XFER_REQ_I(gerr[2]), .TX_XFER_SRV_I(gerr[3]), .RX_FIFO_OVERWRITE_I(gerr[4]),
	.TX_FIFO_STARVE_I(gerr[5]), .TX_CHAN_I(tx_chan), .TX_CLOSE_FLAG_I(close),
	.TX_PAD_VALID_O(pad_valid), .TX_PAD_CHAR_O(pad_char), .TX_PAD_TAKEN_I(taken),
	.TX_BUF_READY_O(buf_ready), .TX_BUF_LEN_O(buf_len), .TX_BUF_PTR_O(buf_ptr),
	.RX_FIRST_SLOT_O(first_slot), .TX_ALIGN_O(tx_align)
);
meq_queue_mem #(.QUEUE_DEPTH(DEPTH), .QIDX_W(IW)) u_mem (
	.clk_i(clk), .rst_i(rst), .stall_i(stall), .qw_valid_i(qw_valid), .qw_index_i(qw_index),
	.qw_data_i(qw_data), .qw_ready_o(qw_ready), .wr_count_o(wr_count)
);
////////////////////////////////////////////////////////////////////////////////
task automatic axi_wr(input logic [7:0] idx, input logic [31:0] v, output logic [1:0] resp);
	logic done;
	done = 1'h0;
	@(posedge clk);
	awaddr  <= {idx, 2'h0};
	wdata   <= v;
	awvalid <= 1'h1;
	wvalid  <= 1'h1;
	bready  <= 1'h1;
	while (!done) begin
		@(posedge clk);
		if (awvalid && awready)
			awvalid <= 1'h0;
		if (wvalid && wready)
			wvalid <= 1'h0;
		if (bvalid) begin
			resp = bresp;
			bready <= 1'h0;
			done = 1'h1;
		end
	end
endtask
task automatic axi_rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] resp);
	logic done;
	done = 1'h0;
	@(posedge clk);
	araddr  <= {idx, 2'h0};
	arvalid <= 1'h1;
	rready  <= 1'h1;
	while (!done) begin
		@(posedge clk);
		if (arvalid && arready)
			arvalid <= 1'h0;
		if (rvalid) begin
			v = rdata;
			resp = rresp;
			rready <= 1'h0;
			done = 1'h1;
		end
	end
endtask
task automatic expect_entry(input logic on, input logic [4:0] ch, input logic [15:0] f);
	logic [15:0] c0;
	logic [15:0] want;
	c0 = wr_count;
	want = {1'h1, exp_idx == DEPTH - 1, 3'h0, ch, 6'h0} | f;
	for (int k = 0; k < 50 && wr_count === c0; k++)
		@(posedge clk);
	if (on) begin
		`MEQ_CHK(u_mem.mem[exp_idx], want)
		axi_rd(`MEQ_IDX_CHAN_EVT, d, r);
		`MEQ_CHK(d[`MEQ_CE_QUEUE_NEW], 1'h1)
		`MEQ_CHK(irq, 1'h1)
		axi_wr(`MEQ_IDX_CHAN_EVT, 32'h4, r);
		repeat (2) @(posedge clk);
		`MEQ_CHK(irq, 1'h0)
		u_mem.clear_entry(exp_idx[IW-1:0]);
		exp_idx = (exp_idx + 1) % DEPTH;
	end else begin
		`MEQ_CHK(wr_count, c0)
		`MEQ_CHK(irq, 1'h0)
	end
endtask
task finish_test;
	$display("Compared %0d values, %0d mismatches", cmp_count, miscompares);
	if (miscompares == 0 && cmp_count > 0)
		$display("All checks passed");
	else
		$display("Checks failed");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	repeat (60000) @(posedge clk);
	miscompares++;
	finish_test();
end
initial begin
	repeat (20) @(posedge clk);
	rst <= 1'h0;
	repeat (2) @(posedge clk);
	axi_rd(`MEQ_IDX_EVT_ENABLE, d, r);
	`MEQ_CHK(d, 32'h0)
	axi_rd(8'h10, d, r);
	`MEQ_CHK(r, `MEQ_RESP_SLVERR)
	axi_wr(`MEQ_IDX_RSVD_A, 32'hffffffff, r);
	`MEQ_CHK(r, `MEQ_RESP_OKAY)
	axi_rd(`MEQ_IDX_RSVD_A, d, r);
	`MEQ_CHK(d, 32'h0)
	axi_wr(`MEQ_IDX_CHAN_MASK, 32'h7, r);
	$display("register test done");
	for (int i = 0; i < 24; i++) begin
		en = (i == 0) ? 16'h0 : (i == 1) ? 16'h17 : $random(seed);
		en = en & `MEQ_EVT_FIELDS;
		fl = (i < 2) ? 16'hffff : $random(seed);
		stall <= i[0];
		axi_wr(`MEQ_IDX_EVT_ENABLE, {16'h0, en}, r);
		@(posedge clk);
		ev_valid <= 1'h1;
		ev_chan  <= 5'(i * 7);
		ev_flags <= fl;
		do @(posedge clk); while (!ev_ready);
		ev_valid <= 1'h0;
		expect_entry((fl & en) != 16'h0, 5'(i * 7), fl & en);
	end
	axi_rd(`MEQ_IDX_QUEUE_STAT, d, r);
	`MEQ_CHK(d[IW-1:0], exp_idx[IW-1:0])
	$display("queue test done");
	axi_wr(`MEQ_IDX_CHAN_MASK, 32'h5, r);
	for (int k = 0; k < 5; k++) begin
		@(posedge clk) gerr <= gp1[k];
		@(posedge clk) gerr <= gp2[k];
		@(posedge clk) gerr <= gp3[k];
		@(posedge clk) gerr <= 6'h0;
		repeat (3) @(posedge clk);
		axi_rd(`MEQ_IDX_CHAN_EVT, d, r);
		`MEQ_CHK(d[2:0], gexp[k])
		`MEQ_CHK(irq, (gexp[k] & 3'h5) != 3'h0)
		axi_wr(`MEQ_IDX_CHAN_EVT, 32'h7, r);
	end
	$display("global error test done");
	for (int k = 0; k < 4; k++) begin
		axi_wr(`MEQ_IDX_EVT_ENABLE, (k == 1) ? 32'h15 : 32'h17, r);
		len = $random(seed) | 1;
		ptr = $random(seed);
		axi_wr(`MEQ_IDX_CHAN_MODE, 32'(tmode[k][0]) << `MEQ_MODE_IDLE_SEL, r);
		axi_wr(`MEQ_IDX_TXD_STAT, 32'h8080 | 32'(tmode[k][1]) << 9 | 32'(tpad[k]), r);
		axi_wr(`MEQ_IDX_TXD_LEN, len, r);
		axi_wr(`MEQ_IDX_TXD_PTR, ptr, r);
		@(posedge clk) close <= 1'h1;
		tx_chan <= 5'(k + 3);
		@(posedge clk) close <= 1'h0;
		n = 0;
		for (int j = 0; j < 60 && n < tpad[k]; j++) begin
			@(posedge clk);
			if (taken) begin
				n++;
				taken <= 1'h0;
			end else if (pad_valid) begin
				`MEQ_CHK(pad_char, tmode[k][0] ? 8'hff : 8'h7e)
				`MEQ_CHK(buf_ready, 1'h1)
				taken <= 1'h1;
			end
		end
		`MEQ_CHK(n, int'(tpad[k]))
		expect_entry(k != 1, 5'(k + 3), 16'h2);
		`MEQ_CHK(pad_valid, 1'h0)
		`MEQ_CHK(buf_ready, tmode[k][1])
		`MEQ_CHK({buf_len, buf_ptr}, {len[15:0], ptr})
		axi_rd(`MEQ_IDX_TXD_STAT, d, r);
		`MEQ_CHK(d[`MEQ_TXD_SW_FLAG], 1'h1)
	end
	$display("transmit close test done");
	axi_wr(`MEQ_IDX_CHAN_MODE, 32'h0, r);
	axi_wr(`MEQ_IDX_SLOT_ALIGN, 32'habcd, r);
	repeat (2) @(posedge clk);
	`MEQ_CHK({first_slot, tx_align}, 16'h0)
	axi_wr(`MEQ_IDX_CHAN_MODE, 32'h1 << `MEQ_MODE_SYNC_EN, r);
	repeat (2) @(posedge clk);
	`MEQ_CHK({first_slot, tx_align}, 16'habcd)
	$display("slot alignment test done");
	finish_test();
end
endmodule // meq_top_test
`default_nettype wire
